// ### core/mrsp_flags.sv
// Purpose: Sticky alert flags and live state bits of the status byte.
// Assumes: Event inputs are synchronous to mclk_i.
// Notes: A set in the clearing cycle wins over the clear.
`timescale 1ns/1ps
`default_nettype none
module mrsp_flags #(
	parameter bit LATCH_OFF = 1'b1
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	input wire logic off_i,
	input wire logic digital_overcurrent_seen_i,
	input wire logic digital_trip_i,
	input wire logic analog_overcurrent_off_i,
	input wire logic swap_failure_i,
	input wire logic swap_failure_alert_enable_i,
	output logic [7:0] status_o
);
	logic dig_alert_reg;
	logic swap_failure_sticky_reg;
	logic off_alert_reg;
	logic off_q_reg;
	logic off_rise;

	// Turn-off edge from pin or force bit
	assign off_rise = off_i & ~off_q_reg;

	// Previous off level
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			off_q_reg <= 1'b0;
		end else begin
			off_q_reg <= off_i;
		end
	end

	// Sticky flags, set beats clear
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			dig_alert_reg <= 1'b0;
			swap_failure_sticky_reg <= 1'b0;
			off_alert_reg <= 1'b0;
		end else begin
			dig_alert_reg <= digital_trip_i | (dig_alert_reg & ~clear_i);
			swap_failure_sticky_reg <= swap_failure_i
				| (swap_failure_sticky_reg & ~clear_i);
			off_alert_reg <= off_rise | (off_alert_reg & ~clear_i);
		end
	end

	// Status byte assembly
	always_comb begin
		status_o = 8'h00;
		status_o[mrsp_pkg::ST_DIG_SEEN] = digital_overcurrent_seen_i;
		status_o[mrsp_pkg::ST_DIG_ALERT] = dig_alert_reg;
		status_o[mrsp_pkg::ST_ANA_OFF] = LATCH_OFF
			? (swap_failure_sticky_reg & swap_failure_alert_enable_i)
			: analog_overcurrent_off_i;
		status_o[mrsp_pkg::ST_SWAP_FAIL] = swap_failure_sticky_reg;
		status_o[mrsp_pkg::ST_OFF] = off_i;
		status_o[mrsp_pkg::ST_OFF_ALERT] = off_alert_reg;
	end

	property p_clear_flags;
		@(posedge mclk_i) disable iff (!rst_n_i)
		clear_i && !digital_trip_i && !swap_failure_i && !off_rise
		|=> status_o[1] == 1'b0 && status_o[3] == 1'b0 && status_o[5] == 1'b0;
	endproperty
	a_clear_flags: assert property (p_clear_flags) else $error("sticky flags not cleared");

	property p_trip_sticky;
		@(posedge mclk_i) disable iff (!rst_n_i)
		digital_trip_i ##1 !clear_i [*3] |-> status_o[1];
	endproperty
	a_trip_sticky: assert property (p_trip_sticky) else $error("trip flag lost");

	property p_off_alert;
		@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(off_i) |=> status_o[5];
	endproperty
	a_off_alert: assert property (p_off_alert) else $error("off alert missed");

	property p_top_zero;
		@(posedge mclk_i) disable iff (!rst_n_i)
		status_o[7:6] == 2'b00;
	endproperty
	a_top_zero: assert property (p_top_zero) else $error("status top bits set");

	c_clear_seen: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		status_o[3] ##1 !status_o[3]);
endmodule : mrsp_flags
`default_nettype wire

// ### core/mrsp_pkg.sv
// Purpose: Shared constants for the monitor readback and status port.
// Assumes: Serial bus pins are sampled by mclk_i and already synchronous.
// Notes: Constants and the slave state type; every user writes mrsp_pkg::name.
package mrsp_pkg;
	// Command byte fields
	localparam int CMD_VOLT_REPEAT = 0;
	localparam int CMD_V_ONCE = 1;
	localparam int CMD_I_CONT = 2;
	localparam int CMD_I_ONCE = 3;
	localparam int CMD_VOLT_ATTEN = 4;
	localparam int CMD_STATUS = 6;
	localparam int BYTE_MSB = 7;
	localparam logic [6:0] CMD_RESET = 7'h00;
	// Extended register selects
	localparam logic [1:0] EXT_ALERT_EN = 2'h1;
	localparam logic [1:0] EXT_ALERT_TH = 2'h2;
	localparam logic [1:0] EXT_CONTROL = 2'h3;
	localparam logic [7:0] ALERT_EN_RESET = 8'h04;
	localparam logic [7:0] ALERT_TH_RESET = 8'hFF;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// Field positions
	localparam int CTL_FORCE_OFF = 0;
	localparam int AEN_SWAP_FAIL = 2;
	localparam int AEN_CLEAR = 4;
	localparam int ST_DIG_SEEN = 0;
	localparam int ST_DIG_ALERT = 1;
	localparam int ST_ANA_OFF = 2;
	localparam int ST_SWAP_FAIL = 3;
	localparam int ST_OFF = 4;
	localparam int ST_OFF_ALERT = 5;
	// Frame geometry
	localparam int BITS_PER_BYTE = 8;
	localparam logic [3:0] BIT_CNT_LAST = 4'h8;
	localparam logic [1:0] FRAME_LAST = 2'h2;
	// Serial slave states
	typedef enum logic [2:0] {
		SL_IDLE = 3'b000,
		SL_RX = 3'b001,
		SL_ACK = 3'b010,
		SL_TX = 3'b011,
		SL_MACK = 3'b100
	} mrsp_state_t;
endpackage : mrsp_pkg

// ### core/mrsp_port.sv
// Purpose: Serial slave for readback frames, status byte and ext writes.
// Assumes: scl_i and sda_i are synchronous to mclk_i and well slower.
// Notes: SDA is open drain; sda_oe_o high pulls the line low.
`timescale 1ns/1ps
`default_nettype none
module mrsp_port #(
	parameter bit LATCH_OFF = 1'b1,
	parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
	parameter int CODE_W = 12
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [6:0] dev_addr_i,
	input wire logic [CODE_W-1:0] voltage_code_i,
	input wire logic [CODE_W-1:0] current_code_i,
	input wire logic voltage_ready_i,
	input wire logic current_ready_i,
	input wire logic hot_swap_enable_pin_i,
	input wire logic digital_overcurrent_seen_i,
	input wire logic digital_trip_i,
	input wire logic analog_overcurrent_off_i,
	input wire logic swap_failure_i,
	output logic hot_swap_off_o,
	output logic [6:0] command_o,
	output logic voltage_repeat_convert_o,
	output logic voltage_attenuation_select_o,
	output logic [7:0] alert_enable_o,
	output logic [7:0] alert_threshold_o,
	output logic [7:0] status_o
);
	mrsp_pkg::mrsp_state_t state_reg;
	logic scl_q_reg;
	logic sda_q_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic rw_reg;
	logic addr_phase_reg;
	logic ext_pending_reg;
	logic [1:0] ext_sel_reg;
	logic [1:0] rd_idx_reg;
	logic mack_reg;
	logic [6:0] command_reg;
	logic [7:0] alert_en_reg;
	logic [7:0] alert_th_reg;
	logic [7:0] control_reg;
	logic sda_oe_reg;
	logic off_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic byte_done;
	logic wr_byte;
	logic load_rd;
	logic [1:0] load_idx;
	logic sel_v;
	logic sel_i;
	logic [CODE_W-1:0] v_code;
	logic [CODE_W-1:0] i_code;
	logic [7:0] tx_byte;
	logic [7:0] status_byte;
	logic pin_off;

	// Builds one byte of a readback frame
	function automatic logic [7:0] frame_byte(input logic [1:0] idx,
			input logic sv, input logic si,
			input logic [CODE_W-1:0] v, input logic [CODE_W-1:0] i);
		logic [7:0] b;
		b = 8'h00;
		if (sv && si) begin
			case (idx)
				2'h0: b = v[11:4];
				2'h1: b = i[11:4];
				2'h2: b = {v[3:0], i[3:0]};
				default: b = 8'h00;
			endcase
		end else if (sv) begin
			if (idx == 2'h0) begin
				b = v[11:4];
			end else if (idx == 2'h1) begin
				b = {v[3:0], 4'h0};
			end
		end else if (si) begin
			if (idx == 2'h0) begin
				b = i[11:4];
			end else if (idx == 2'h1) begin
				b = {i[3:0], 4'h0};
			end
		end
		return b;
	endfunction : frame_byte

	// Bus condition detection
	assign scl_rise = scl_i & ~scl_q_reg;
	assign scl_fall = ~scl_i & scl_q_reg;
	assign start_cond = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
	assign stop_cond = scl_i & scl_q_reg & ~sda_q_reg & sda_i;
	assign byte_done = scl_fall && bit_cnt_reg == mrsp_pkg::BIT_CNT_LAST;

	// Channel selection and not-yet-converted masking
	assign sel_v = command_reg[mrsp_pkg::CMD_VOLT_REPEAT] | command_reg[mrsp_pkg::CMD_V_ONCE];
	assign sel_i = command_reg[mrsp_pkg::CMD_I_CONT] | command_reg[mrsp_pkg::CMD_I_ONCE];
	assign v_code = voltage_ready_i ? voltage_code_i : '0;
	assign i_code = current_ready_i ? current_code_i : '0;

	// Byte to shift out next
	assign load_rd = (state_reg == mrsp_pkg::SL_ACK && scl_fall && rw_reg)
		|| (state_reg == mrsp_pkg::SL_MACK && scl_fall && mack_reg);
	assign load_idx = (state_reg == mrsp_pkg::SL_ACK) ? 2'h0 : rd_idx_reg + 2'h1;
	assign tx_byte = command_reg[mrsp_pkg::CMD_STATUS] ? status_byte
		: frame_byte(load_idx, sel_v, sel_i, v_code, i_code);
	assign wr_byte = state_reg == mrsp_pkg::SL_RX && byte_done && !addr_phase_reg && !rw_reg;

	// Pin sampling history
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end else begin
			scl_q_reg <= scl_i;
			sda_q_reg <= sda_i;
		end
	end

	// Slave sequencing, shifting and line drive
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_reg <= mrsp_pkg::SL_IDLE;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			rw_reg <= 1'b0;
			addr_phase_reg <= 1'b0;
			rd_idx_reg <= 2'h0;
			mack_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (start_cond) begin
			state_reg <= mrsp_pkg::SL_RX;
			bit_cnt_reg <= 4'h0;
			addr_phase_reg <= 1'b1;
			rw_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (stop_cond) begin
			state_reg <= mrsp_pkg::SL_IDLE;
			sda_oe_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				mrsp_pkg::SL_IDLE: begin
					sda_oe_reg <= 1'b0;
				end
				mrsp_pkg::SL_RX: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_i};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (byte_done) begin
						if (addr_phase_reg && shift_reg[7:1] != dev_addr_i) begin
							state_reg <= mrsp_pkg::SL_IDLE;
						end else begin
							state_reg <= mrsp_pkg::SL_ACK;
							sda_oe_reg <= 1'b1;
							if (addr_phase_reg) begin
								rw_reg <= shift_reg[0];
							end
						end
						addr_phase_reg <= 1'b0;
					end
				end
				mrsp_pkg::SL_ACK: begin
					if (scl_fall) begin
						bit_cnt_reg <= 4'h0;
						if (rw_reg) begin
							state_reg <= mrsp_pkg::SL_TX;
							shift_reg <= tx_byte;
							rd_idx_reg <= load_idx;
							sda_oe_reg <= ~tx_byte[mrsp_pkg::BYTE_MSB];
						end else begin
							state_reg <= mrsp_pkg::SL_RX;
							sda_oe_reg <= 1'b0;
						end
					end
				end
				mrsp_pkg::SL_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == mrsp_pkg::BIT_CNT_LAST - 4'h1) begin
							state_reg <= mrsp_pkg::SL_MACK;
							sda_oe_reg <= 1'b0;
						end else begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							sda_oe_reg <= ~shift_reg[6];
						end
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
				mrsp_pkg::SL_MACK: begin
					if (scl_rise) begin
						mack_reg <= ~sda_i;
					end else if (scl_fall) begin
						bit_cnt_reg <= 4'h0;
						if (mack_reg) begin
							state_reg <= mrsp_pkg::SL_TX;
							shift_reg <= tx_byte;
							rd_idx_reg <= load_idx;
							sda_oe_reg <= ~tx_byte[mrsp_pkg::BYTE_MSB];
						end else begin
							state_reg <= mrsp_pkg::SL_IDLE;
						end
					end
				end
				default: begin
					state_reg <= mrsp_pkg::SL_IDLE;
					sda_oe_reg <= 1'b0;
				end
			endcase
		end
	end

	// Command byte versus extended address decode
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			command_reg <= mrsp_pkg::CMD_RESET;
			ext_pending_reg <= 1'b0;
			ext_sel_reg <= 2'h0;
		end else if (start_cond) begin
			ext_pending_reg <= 1'b0;
		end else if (wr_byte) begin
			if (ext_pending_reg) begin
				ext_pending_reg <= 1'b0;
			end else if (shift_reg[mrsp_pkg::BYTE_MSB]) begin
				ext_pending_reg <= 1'b1;
				ext_sel_reg <= shift_reg[1:0];
			end else begin
				command_reg <= shift_reg[6:0];
			end
		end
	end

	// Extended registers; clear bit drops one cycle after it is written
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			alert_en_reg <= mrsp_pkg::ALERT_EN_RESET;
			alert_th_reg <= mrsp_pkg::ALERT_TH_RESET;
			control_reg <= mrsp_pkg::CONTROL_RESET;
		end else if (wr_byte && ext_pending_reg) begin
			unique case (ext_sel_reg)
				mrsp_pkg::EXT_ALERT_EN: alert_en_reg <= shift_reg;
				mrsp_pkg::EXT_ALERT_TH: alert_th_reg <= shift_reg;
				mrsp_pkg::EXT_CONTROL: control_reg <= shift_reg;
				default: alert_en_reg <= alert_en_reg;
			endcase
		end else begin
			alert_en_reg[mrsp_pkg::AEN_CLEAR] <= 1'b0;
		end
	end

	// Off state from pin or software force
	assign pin_off = ENABLE_ACTIVE_HIGH ? ~hot_swap_enable_pin_i : hot_swap_enable_pin_i;
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			off_reg <= 1'b0;
		end else begin
			off_reg <= pin_off | control_reg[mrsp_pkg::CTL_FORCE_OFF];
		end
	end

	// Status flag keeper
	mrsp_flags #(
		.LATCH_OFF(LATCH_OFF)
	) u_flags (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clear_i(alert_en_reg[mrsp_pkg::AEN_CLEAR]),
		.off_i(off_reg),
		.digital_overcurrent_seen_i(digital_overcurrent_seen_i),
		.digital_trip_i(digital_trip_i),
		.analog_overcurrent_off_i(analog_overcurrent_off_i),
		.swap_failure_i(swap_failure_i),
		.swap_failure_alert_enable_i(alert_en_reg[mrsp_pkg::AEN_SWAP_FAIL]),
		.status_o(status_byte)
	);

	// Output drive
	assign sda_o = 1'b0;
	assign sda_oe_o = sda_oe_reg;
	assign hot_swap_off_o = off_reg;
	assign command_o = command_reg;
	assign voltage_repeat_convert_o = command_reg[mrsp_pkg::CMD_VOLT_REPEAT];
	assign voltage_attenuation_select_o = command_reg[mrsp_pkg::CMD_VOLT_ATTEN];
	assign alert_enable_o = alert_en_reg;
	assign alert_threshold_o = alert_th_reg;
	assign status_o = status_byte;

	property p_force_off;
		@(posedge mclk_i) disable iff (!rst_n_i)
		control_reg[0] |=> hot_swap_off_o && status_o[4];
	endproperty
	a_force_off: assert property (p_force_off) else $error("force off ignored");

	property p_ack_drive;
		@(posedge mclk_i) disable iff (!rst_n_i)
		state_reg == mrsp_pkg::SL_ACK |-> sda_oe_o;
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

	property p_both_third;
		@(posedge mclk_i) disable iff (!rst_n_i)
		load_rd && load_idx == 2'h2 && sel_v && sel_i && !command_reg[6]
		|=> shift_reg == {$past(v_code[3:0]), $past(i_code[3:0])};
	endproperty
	a_both_third: assert property (p_both_third) else $error("third byte wrong");

	property p_v_second;
		@(posedge mclk_i) disable iff (!rst_n_i)
		load_rd && load_idx == 2'h1 && sel_v && !sel_i && !command_reg[6]
		|=> shift_reg == {$past(v_code[3:0]), 4'h0};
	endproperty
	a_v_second: assert property (p_v_second) else $error("voltage lsb byte wrong");

	property p_i_second;
		@(posedge mclk_i) disable iff (!rst_n_i)
		load_rd && load_idx == 2'h1 && !sel_v && sel_i && !command_reg[6]
		|=> shift_reg == {$past(i_code[3:0]), 4'h0};
	endproperty
	a_i_second: assert property (p_i_second) else $error("current lsb byte wrong");

	property p_status_rd;
		@(posedge mclk_i) disable iff (!rst_n_i)
		load_rd && command_reg[6] |=> shift_reg == $past(status_byte);
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status byte not sent");

	property p_not_ready;
		@(posedge mclk_i) disable iff (!rst_n_i)
		load_rd && load_idx == 2'h0 && sel_v && !voltage_ready_i && !command_reg[6]
		|=> shift_reg == 8'h00;
	endproperty
	a_not_ready: assert property (p_not_ready) else $error("unconverted data nonzero");

	property p_clear_self;
		@(posedge mclk_i) disable iff (!rst_n_i)
		alert_en_reg[4] && !wr_byte |=> !alert_en_reg[4];
	endproperty
	a_clear_self: assert property (p_clear_self) else $error("clear bit stuck");

	c_three_bytes: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		load_rd && load_idx == 2'h2);
	c_status_read: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		load_rd && command_reg[6]);
	c_ext_write: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		wr_byte && ext_pending_reg);
endmodule : mrsp_port
`default_nettype wire

// ### tb/mrsp_master.sv
// Purpose: Serial bus master model that drives the readback port.
// Assumes: SDA is open drain with a pull-up; scl is driven push-pull.
// Notes: Lines change only at mclk edges; scl stays high between frames.
`timescale 1ns/1ps
`default_nettype none
module mrsp_master #(
	parameter int HALF = 4
) (
	input wire logic mclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	// Idle bus: clock high, data released
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : tick

	// One bit: data set while clock low, sampled late in the high phase
	task automatic put_bit(input logic b, output logic s);
		sda_oe_o <= ~b;
		tick(HALF);
		scl_o <= 1'b1;
		tick(HALF);
		s = sda_i;
		scl_o <= 1'b0;
		tick(HALF);
	endtask : put_bit

	// Start condition: data falls while clock high
	task automatic bus_start();
		sda_oe_o <= 1'b1;
		tick(HALF);
		scl_o <= 1'b0;
		tick(HALF);
	endtask : bus_start

	// Stop condition: data rises while clock high
	task automatic bus_stop();
		sda_oe_o <= 1'b1;
		tick(HALF);
		scl_o <= 1'b1;
		tick(HALF);
		sda_oe_o <= 1'b0;
		tick(HALF);
	endtask : bus_stop

	// Sends a byte MSB first and returns the slave acknowledge
	task automatic byte_out(input logic [7:0] d, output logic ack);
		logic s;
		for (int k = 7; k >= 0; k--) begin
			put_bit(d[k], s);
		end
		put_bit(1'b1, s);
		ack = ~s;
	endtask : byte_out

	// Receives a byte; the final byte is answered with a not-acknowledge
	task automatic byte_in(input logic last, output logic [7:0] d);
		logic s;
		for (int k = 7; k >= 0; k--) begin
			put_bit(1'b1, d[k]);
		end
		put_bit(last, s);
	endtask : byte_in
endmodule : mrsp_master
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the readback and status port.
// Assumes: Master model paces the bus far slower than mclk.
// Notes: Status bytes are judged both on the bus and at ports; frame bytes on the bus only.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [6:0] ADDR = 7'h2A;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic pin = 1'b1;
	logic [11:0] vcode = 12'hA5C;
	logic [11:0] icode = 12'h3B7;
	logic vrdy = 1'b1;
	logic irdy = 1'b1;
	logic dseen = 1'b0;
	logic dtrip = 1'b0;
	logic sfail = 1'b0;
	logic scl, m_oe, d_oe, d_sda, hs_off, vrep, vatt;
	logic [6:0] cmd;
	logic [7:0] aen, ath, stat;
	logic [7:0] rbuf [3];
	int num_errors = 0;
	int n_checks = 0;
	wire sda = ~(m_oe | d_oe);

	always #5 mclk = ~mclk;

	mrsp_master i_master (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

	mrsp_port i_dut (.mclk_i(mclk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
		.sda_o(d_sda), .sda_oe_o(d_oe), .dev_addr_i(ADDR), .voltage_code_i(vcode),
		.current_code_i(icode), .voltage_ready_i(vrdy), .current_ready_i(irdy),
		.hot_swap_enable_pin_i(pin), .digital_overcurrent_seen_i(dseen),
		.digital_trip_i(dtrip), .analog_overcurrent_off_i(1'b0), .swap_failure_i(sfail),
		.hot_swap_off_o(hs_off), .command_o(cmd), .voltage_repeat_convert_o(vrep),
		.voltage_attenuation_select_o(vatt), .alert_enable_o(aen),
		.alert_threshold_o(ath), .status_o(stat));

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// Write transaction of one or two bytes
	task automatic wr(input logic [7:0] b1, input logic [7:0] b2, input bit two);
		logic a;
		i_master.bus_start();
		i_master.byte_out({ADDR, 1'b0}, a);
		check({7'h00, a}, 8'h01, "write address ack");
		i_master.byte_out(b1, a);
		if (two) begin
			i_master.byte_out(b2, a);
		end
		i_master.bus_stop();
		tick(3);
	endtask : wr

	// Read transaction of n bytes into rbuf
	task automatic rd(input int n);
		logic a;
		i_master.bus_start();
		i_master.byte_out({ADDR, 1'b1}, a);
		check({7'h00, a}, 8'h01, "read address ack");
		for (int k = 0; k < n; k++) begin
			i_master.byte_in(k == n - 1, rbuf[k]);
		end
		i_master.bus_stop();
	endtask : rd

	// Expected byte k of a frame: kind 0 both, 1 voltage, 2 current
	function automatic logic [7:0] fexp(input int kind, input int k);
		logic [11:0] v, c;
		v = vrdy ? vcode : 12'h000;
		c = irdy ? icode : 12'h000;
		if (kind == 0) begin
			return (k == 0) ? v[11:4] : (k == 1) ? c[11:4] : {v[3:0], c[3:0]};
		end
		if (kind == 1) begin
			return (k == 0) ? v[11:4] : {v[3:0], 4'h0};
		end
		return (k == 0) ? c[11:4] : {c[3:0], 4'h0};
	endfunction : fexp

	task automatic t_reset();
		check(aen, 8'h04, "alert enable reset");
		check(ath, 8'hFF, "threshold reset");
		check({1'b0, cmd}, 8'h00, "command reset");
		check({7'h00, d_sda}, 8'h00, "open drain data level");
		check({7'h00, hs_off}, 8'h00, "off after reset");
		check(stat, 8'h00, "status reset");
	endtask : t_reset

	// Every conversion mode, with and without ready data
	task automatic t_frames();
		logic [7:0] cmds [6] = '{8'h05, 8'h0A, 8'h01, 8'h02, 8'h04, 8'h08};
		int kinds [6] = '{0, 0, 1, 1, 2, 2};
		for (int r = 0; r < 2; r++) begin
			for (int m = 0; m < 6; m++) begin
				wr(cmds[m], 8'h00, 1'b0);
				rd(kinds[m] == 0 ? 3 : 2);
				for (int k = 0; k < (kinds[m] == 0 ? 3 : 2); k++) begin
					check(rbuf[k], fexp(kinds[m], k), "frame byte");
				end
			end
			vrdy <= 1'b0;
			irdy <= 1'b0;
			tick(1);
		end
		vrdy <= 1'b1;
		irdy <= 1'b1;
		wr(8'h11, 8'h00, 1'b0);
		check({1'b0, cmd}, 8'h11, "command byte");
		check({6'h00, vrep, vatt}, 8'h03, "mode outputs");
	endtask : t_frames

	// Software force-off and pin-off
	task automatic t_force();
		wr(8'h83, 8'h01, 1'b1);
		check({7'h00, hs_off}, 8'h01, "forced off");
		check(stat & 8'h30, 8'h30, "off status and alert");
		wr(8'h83, 8'h00, 1'b1);
		check({7'h00, hs_off}, 8'h00, "force released");
		check(stat & 8'h30, 8'h20, "alert stays");
		pin <= 1'b0;
		tick(3);
		check({7'h00, hs_off}, 8'h01, "pin off");
		check(stat & 8'h10, 8'h10, "pin off status");
		pin <= 1'b1;
		tick(3);
	endtask : t_force

	// Sticky flags, status readback and clear
	task automatic t_status();
		dtrip <= 1'b1;
		sfail <= 1'b1;
		dseen <= 1'b1;
		tick(1);
		dtrip <= 1'b0;
		sfail <= 1'b0;
		tick(3);
		check(stat, 8'h2F, "flags set");
		wr(8'h40, 8'h00, 1'b0);
		rd(1);
		check(rbuf[0], 8'h2F, "status over bus");
		wr(8'h81, 8'h14, 1'b1);
		check(aen, 8'h04, "clear self-clears");
		check(stat, 8'h01, "sticky cleared");
		rd(1);
		check(rbuf[0], 8'h01, "status after clear");
		dseen <= 1'b0;
		tick(2);
		check(stat, 8'h00, "live bit follows");
	endtask : t_status

	// Wrong address, unused select, threshold write
	task automatic t_refuse();
		logic a;
		i_master.bus_start();
		i_master.byte_out({ADDR ^ 7'h01, 1'b0}, a);
		i_master.bus_stop();
		check({7'h00, a}, 8'h00, "foreign address");
		wr(8'h80, 8'h55, 1'b1);
		check(aen, 8'h04, "select zero ignored");
		check(ath, 8'hFF, "select zero ignored");
		wr(8'h82, 8'h5A, 1'b1);
		check(ath, 8'h5A, "threshold written");
	endtask : t_refuse

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		tick(3);
		rst_n <= 1'b1;
		tick(3);
		t_reset();
		t_frames();
		t_force();
		t_status();
		t_refuse();
		report_and_stop();
	end

	// Watchdog well beyond the expected run length
	initial begin
		tick(80000);
		num_errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
